//--- rtl/homing_pkg.sv
// Constants for the two-channel homing pulse generator.
// Assumes a single 25 MHz clock and a plain word-addressed register port.
package homing_pkg;

   // ----------------------------------------------------------------
   // Clocking and widths
   // ----------------------------------------------------------------
   localparam int unsigned CLOCK_HZ = 25_000_000;    // Reference clock rate
   localparam int ADDR_W = 8;                        // Register address width
   localparam int DATA_W = 16;                       // Register data width
   localparam int CNT_W = 24;                        // Half period counter width
   localparam int CHANNELS = 2;                      // Homing channels

   // ----------------------------------------------------------------
   // Register map: channel block stride and word offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] CH_STRIDE = 8'h10;         // Address step per channel
   localparam logic [3:0] OFF_INIT_FREQ = 4'h0;      // Initial frequency word
   localparam logic [3:0] OFF_CREEP_FREQ = 4'h1;     // Creep frequency word
   localparam logic [3:0] OFF_ERROR = 4'h2;          // Error status word
   localparam logic [3:0] OFF_MODE = 4'h3;           // Mode bits
   localparam logic [3:0] OFF_PARAM_BASE = 4'h4;     // Parameter block base
   localparam logic [3:0] OFF_STATUS_BASE = 4'h5;    // Status relay base
   localparam logic [3:0] OFF_BLOCK_INDEX = 4'h6;    // Block index
   localparam logic [3:0] OFF_STATE = 4'h7;          // Live status bits

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int MODE_INIT_BIT = 0;                 // Initial freq mode
   localparam int MODE_CREEP_BIT = 1;                // Creep freq mode
   localparam int STATE_ON_BIT = 0;                  // Pulse output on
   localparam int STATE_DONE_BIT = 1;                // Pulse output complete

   // ----------------------------------------------------------------
   // Reset and preload values, legal ranges
   // ----------------------------------------------------------------
   localparam logic [15:0] DEF_INIT_FREQ = 16'h0064; // 100
   localparam logic [15:0] DEF_CREEP_FREQ = 16'h0064;// 100
   localparam logic [1:0] DEF_MODE = 2'h0;           // Both mode 0
   localparam logic [15:0] FREQ_MAX = 16'h2710;      // 10000
   localparam logic [15:0] FREQ_MIN_M0 = 16'h0001;   // 1 Hz steps
   localparam logic [15:0] FREQ_MIN_M1 = 16'h0014;   // 20, 10 Hz steps
   localparam logic [15:0] MODE1_SCALE = 16'h000a;   // x10 Hz
   localparam logic [15:0] ERR_NONE = 16'h0000;      // No error
   localparam logic [15:0] ERR_RANGE = 16'h0002;     // Setting out of range
   localparam logic [15:0] PBASE_LO_MAX = 16'h03e5;  // 997
   localparam logic [15:0] PBASE_HI_MIN = 16'h03e8;  // 1000
   localparam logic [15:0] PBASE_HI_MAX = 16'h07cd;  // 1997
   localparam logic [15:0] SBASE_MAX = 16'h03f8;     // M1270: word 127, bit 0
   localparam logic [2:0] SBASE_LOW_DIGIT = 3'h0;    // Lowest octal digit
   localparam logic [15:0] BLOCK_MAX = 16'h03e7;     // 999
   localparam logic [15:0] DEF_PBASE_A = 16'h0000;   // Channel a base
   localparam logic [15:0] DEF_PBASE_B = 16'h0003;   // Channel b base
   localparam logic [15:0] DEF_SBASE_A = 16'h0000;   // Channel a relays
   localparam logic [15:0] DEF_SBASE_B = 16'h0008;   // Channel b relays

   // ----------------------------------------------------------------
   // Channel states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      IDLE = 3'b001,                                 // No pulses
      FAST = 3'b010,                                 // Initial frequency
      CREEP = 3'b100                                 // Creep frequency
   } phase_type;

endpackage

//--- rtl/homing_pulse.sv
// Two-channel homing pulse generator with a plain register port.
// Assumes inputs synchronous to CLOCK and one scan per enabled clock.
//
// Overview of operation
// - Run, no slowdown: pulses at initial frequency
// - Slowdown on: pulses at creep frequency
// - Slowdown off after creep: stop, finished
// - Run off stops pulses at once
// - Preload rewrites defaults every scan
// - Completion sets a sticky done flag
// - Run turning on clears done flag
// - Parameter block three words, base range checked
// - Two status bits, base up to 1270
// - Two independent channels, own outputs
// - Unique block index 0 to 999
// - Channel a port 14, channel b 15
// - Word layout and frequency ranges per mode
// - On bit while pulsing, done bit
`timescale 1ns/1ns
`default_nettype none

module homing_pulse
   import homing_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RSTN,
   input wire logic CE,
   input wire logic [homing_pkg::CHANNELS-1:0] RUN,
   input wire logic [homing_pkg::CHANNELS-1:0] SLOWDOWN,
   input wire logic [homing_pkg::CHANNELS-1:0] PRELOAD,
   input wire logic [homing_pkg::ADDR_W-1:0] ADDR,
   input wire logic [homing_pkg::DATA_W-1:0] WDATA,
   input wire logic WE,
   input wire logic RE,
   output logic [homing_pkg::DATA_W-1:0] RDATA,
   output logic PULSE_PORT14,
   output logic PULSE_PORT15,
   output logic [homing_pkg::CHANNELS-1:0] PULSE_ON,
   output logic [homing_pkg::CHANNELS-1:0] PULSE_DONE
);
   import homing_pkg::*;

   // ----------------------------------------------------------------
   // Per channel storage
   // ----------------------------------------------------------------
   logic [15:0] init_freq [CHANNELS];   // Initial frequency word
   logic [15:0] creep_freq [CHANNELS];  // Creep frequency word
   logic [15:0] error_word [CHANNELS];  // Error status word
   logic [1:0] mode [CHANNELS];         // Mode bits
   logic [15:0] param_base [CHANNELS];  // Parameter block base
   logic [15:0] status_base [CHANNELS]; // Status relay base
   logic [15:0] block_index [CHANNELS]; // Block index
   logic [CHANNELS-1:0] pulse;          // Pulse levels
   logic [CHANNELS-1:0] run_on;         // Channel emitting

   // Half period in clocks for a frequency word and its mode
   function automatic logic [CNT_W-1:0] half_count(input logic [15:0] f, input logic m);
      logic [31:0] hz;
      hz = m ? 32'(f) * 32'(MODE1_SCALE) : 32'(f);
      if (hz == 32'h0)
         hz = 32'h1;
      half_count = CNT_W'(CLOCK_HZ / (2 * hz));
      if (half_count == '0)
         half_count = CNT_W'(1);
   endfunction

   // Frequency word inside the legal range for its mode
   function automatic logic freq_ok(input logic [15:0] f, input logic m);
      freq_ok = (f <= FREQ_MAX) && (f >= (m ? FREQ_MIN_M1 : FREQ_MIN_M0));
   endfunction

   // ----------------------------------------------------------------
   // Channels
   // ----------------------------------------------------------------
   genvar ch;
   generate
      for (ch = 0; ch < CHANNELS; ch++) begin : g_ch
         localparam logic [7:0] BASE = 8'(ch * 16);
         localparam int OTHER = 1 - ch;
         phase_type phase;         // Move phase
         logic run_prev;           // Run level last scan
         logic [CNT_W-1:0] count;  // Half period countdown
         logic sel;                // Write hits this channel
         logic [3:0] off;          // Word within channel block
         logic [15:0] next_init;   // Initial word after write
         logic [15:0] next_creep;  // Creep word after write
         logic [1:0] next_mode;    // Mode after write

         assign sel = WE && (ADDR[7:4] == BASE[7:4]);
         assign off = ADDR[3:0];
         assign next_init = (sel && off == OFF_INIT_FREQ) ? WDATA : init_freq[ch];
         assign next_creep = (sel && off == OFF_CREEP_FREQ) ? WDATA : creep_freq[ch];
         assign next_mode = (sel && off == OFF_MODE) ? WDATA[1:0] : mode[ch];

         // Frequency words and modes; preload outranks software
         always_ff @(posedge CLOCK or negedge RSTN) begin
            if (!RSTN) begin
               init_freq[ch] <= DEF_INIT_FREQ;
               creep_freq[ch] <= DEF_CREEP_FREQ;
               mode[ch] <= DEF_MODE;
            end else if (CE) begin
               if (PRELOAD[ch]) begin
                  init_freq[ch] <= DEF_INIT_FREQ;
                  creep_freq[ch] <= DEF_CREEP_FREQ;
                  mode[ch] <= DEF_MODE;
               end else begin
                  init_freq[ch] <= next_init;
                  creep_freq[ch] <= next_creep;
                  mode[ch] <= next_mode;
               end
            end
         end

         // Error word tracks range check of the settings
         always_ff @(posedge CLOCK or negedge RSTN) begin
            if (!RSTN) begin
               error_word[ch] <= ERR_NONE;
            end else if (CE) begin
               if (freq_ok(init_freq[ch], mode[ch][MODE_INIT_BIT])
                   && freq_ok(creep_freq[ch], mode[ch][MODE_CREEP_BIT]))
                  error_word[ch] <= ERR_NONE;
               else
                  error_word[ch] <= ERR_RANGE;
            end
         end

         // Base and index settings; illegal writes are dropped
         always_ff @(posedge CLOCK or negedge RSTN) begin
            if (!RSTN) begin
               param_base[ch] <= (ch == 0) ? DEF_PBASE_A : DEF_PBASE_B;
               status_base[ch] <= (ch == 0) ? DEF_SBASE_A : DEF_SBASE_B;
               block_index[ch] <= 16'(ch);
            end else if (CE && sel) begin
               // Base kept in either data word range
               if (off == OFF_PARAM_BASE && (WDATA <= PBASE_LO_MAX
                   || (WDATA >= PBASE_HI_MIN && WDATA <= PBASE_HI_MAX)))
                  param_base[ch] <= WDATA;
               // Relay base range and low digit
               if (off == OFF_STATUS_BASE && WDATA <= SBASE_MAX
                   && WDATA[2:0] == SBASE_LOW_DIGIT)
                  status_base[ch] <= WDATA;
               // Index unique and in range
               if (off == OFF_BLOCK_INDEX && WDATA <= BLOCK_MAX
                   && WDATA != block_index[OTHER])
                  block_index[ch] <= WDATA;
            end
         end

         // Move sequencing
         always_ff @(posedge CLOCK or negedge RSTN) begin
            if (!RSTN) begin
               phase <= IDLE;
               run_prev <= 1'b0;
               PULSE_DONE[ch] <= 1'b0;
            end else if (CE) begin
               run_prev <= RUN[ch];
               unique case (phase)
                  IDLE: begin
                     // Start on a rising run request
                     if (RUN[ch] && !run_prev) begin
                        PULSE_DONE[ch] <= 1'b0;
                        if (error_word[ch] == ERR_NONE)
                           phase <= SLOWDOWN[ch] ? CREEP : FAST;
                     end
                  end
                  FAST: begin
                     if (!RUN[ch])
                        phase <= IDLE;
                     else if (SLOWDOWN[ch])
                        phase <= CREEP;
                  end
                  CREEP: begin
                     if (!RUN[ch]) begin
                        phase <= IDLE;
                     end else if (!SLOWDOWN[ch]) begin
                        phase <= IDLE;
                        PULSE_DONE[ch] <= 1'b1;
                     end
                  end
               endcase
            end
         end

         // Divider: reload only at a pulse edge
         always_ff @(posedge CLOCK or negedge RSTN) begin
            if (!RSTN) begin
               count <= '0;
               pulse[ch] <= 1'b0;
               run_on[ch] <= 1'b0;
            end else if (CE) begin
               run_on[ch] <= (phase != IDLE) && RUN[ch];
               if (phase == IDLE || !RUN[ch]) begin
                  count <= '0;
                  pulse[ch] <= 1'b0;
               end else if (count == '0) begin
                  pulse[ch] <= ~pulse[ch];
                  if (phase == CREEP || SLOWDOWN[ch])
                     count <= half_count(creep_freq[ch], mode[ch][MODE_CREEP_BIT]) - CNT_W'(1);
                  else
                     count <= half_count(init_freq[ch], mode[ch][MODE_INIT_BIT]) - CNT_W'(1);
               end else begin
                  count <= count - CNT_W'(1);
               end
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Output ports
   // ----------------------------------------------------------------
   // Pins follow the pulse registers with one flop each
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         PULSE_PORT14 <= 1'b0;
         PULSE_PORT15 <= 1'b0;
         PULSE_ON <= '0;
      end else if (CE) begin
         PULSE_PORT14 <= pulse[0];
         PULSE_PORT15 <= pulse[1];
         PULSE_ON <= run_on;
      end
   end

   // ----------------------------------------------------------------
   // Register read port
   // ----------------------------------------------------------------
   // Read data for the cycle after the strobe; zero otherwise
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         RDATA <= '0;
      end else if (CE) begin
         RDATA <= '0;
         if (RE && ADDR[7:4] < 4'(CHANNELS)) begin
            unique case (ADDR[3:0])
               OFF_INIT_FREQ: RDATA <= init_freq[ADDR[4]];
               OFF_CREEP_FREQ: RDATA <= creep_freq[ADDR[4]];
               OFF_ERROR: RDATA <= error_word[ADDR[4]];
               OFF_MODE: RDATA <= {14'h0000, mode[ADDR[4]]};
               OFF_PARAM_BASE: RDATA <= param_base[ADDR[4]];
               OFF_STATUS_BASE: RDATA <= status_base[ADDR[4]];
               OFF_BLOCK_INDEX: RDATA <= block_index[ADDR[4]];
               OFF_STATE: RDATA <= {14'h0000, PULSE_DONE[ADDR[4]], PULSE_ON[ADDR[4]]};
               default: RDATA <= '0;
            endcase
         end
      end
   end

endmodule

`default_nettype wire

//--- tb/homing_pulse_properties.sv
// Port checker for the two-channel homing pulse generator.
// Assumes CE stays high whenever a run request changes; bound to every homing_pulse.
`timescale 1ns/1ns
`default_nettype none
module homing_pulse_properties
   import homing_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RSTN,
   input wire logic CE,
   input wire logic [homing_pkg::CHANNELS-1:0] RUN,
   input wire logic [homing_pkg::CHANNELS-1:0] SLOWDOWN,
   input wire logic [homing_pkg::CHANNELS-1:0] PRELOAD,
   input wire logic [homing_pkg::ADDR_W-1:0] ADDR,
   input wire logic [homing_pkg::DATA_W-1:0] WDATA,
   input wire logic WE,
   input wire logic RE,
   input wire logic [homing_pkg::DATA_W-1:0] RDATA,
   input wire logic PULSE_PORT14,
   input wire logic PULSE_PORT15,
   input wire logic [homing_pkg::CHANNELS-1:0] PULSE_ON,
   input wire logic [homing_pkg::CHANNELS-1:0] PULSE_DONE
);
   default clocking main_cb @(posedge CLOCK); endclocking
   default disable iff (!RSTN);
   // ------------------------------------------------------------
   // Move steps
   // ------------------------------------------------------------
   sequence s_start_a;
      !RUN[0] ##1 RUN[0] [*3];
   endsequence
   sequence s_done_held;
      PULSE_DONE[0] [*3];
   endsequence
   // ------------------------------------------------------------
   // Channel a start, stop and completion flag
   // ------------------------------------------------------------
   a_start_timing: assert property (s_start_a |=> PULSE_ON[0] && PULSE_PORT14)
      else $error("channel a start not on time");
   a_run_off_a: assert property (!RUN[0] [*4] |-> !PULSE_PORT14 && !PULSE_ON[0])
      else $error("channel a still active without run");
   a_done_clear: assert property ($rose(RUN[0]) |=> !PULSE_DONE[0])
      else $error("done flag not cleared at start");
   a_done_sticky: assert property ($fell(PULSE_DONE[0]) |-> $past(RUN[0]) && !$past(RUN[0], 2))
      else $error("done flag dropped without a start");
   a_done_cause: assert property ($rose(PULSE_DONE[0]) |-> $past(RUN[0]) && !$past(SLOWDOWN[0]))
      else $error("done flag rose without slowdown release");
   a_stop_after_done: assert property (s_done_held |-> !PULSE_ON[0] && !PULSE_PORT14)
      else $error("pulses continue after completion");
   // ------------------------------------------------------------
   // Channel b and register port
   // ------------------------------------------------------------
   a_run_off_b: assert property (!RUN[1] [*4] |-> !PULSE_PORT15 && !PULSE_ON[1])
      else $error("channel b still active without run");
   a_done_fell_b: assert property ($fell(PULSE_DONE[1]) |-> $past(RUN[1]) && !$past(RUN[1], 2))
      else $error("channel b done dropped without a start");
   a_read_idle: assert property (!$past(RE) |-> RDATA == 16'h0000)
      else $error("read data present without a read");
endmodule
bind homing_pulse homing_pulse_properties i_homing_pulse_properties (.CLOCK, .RSTN, .CE, .RUN,
   .SLOWDOWN, .PRELOAD, .ADDR, .WDATA, .WE, .RE, .RDATA, .PULSE_PORT14, .PULSE_PORT15,
   .PULSE_ON, .PULSE_DONE);
`default_nettype wire

//--- tb/homing_pulse_test.sv
// Self-checking bench for the homing pulse generator.
// Assumes the checker binds itself; the drive model counts steps.
`timescale 1ns/1ns
`default_nettype none
module homing_pulse_test;
   import homing_pkg::*;
   logic CLOCK, RSTN, CE, WE, RE;
   logic [1:0] RUN, SLOWDOWN, PRELOAD, PULSE_ON, PULSE_DONE;
   logic [7:0] ADDR, base;
   logic [15:0] WDATA, RDATA, rd_val;
   logic PULSE_PORT14, PULSE_PORT15;
   logic [31:0] n, other;
   int c;
   int bad_count = 0;
   int total_checks = 0;
   wire [1:0] pins = {PULSE_PORT15, PULSE_PORT14};
   typedef struct {logic w; logic [7:0] a; logic [15:0] d; logic [15:0] e;} reg_row_type;
   typedef struct {int ch; logic [1:0] m; logic [15:0] fi; logic [15:0] fc;} run_row_type;
   // Register rows: write flag, address, data, expected read
   reg_row_type regs [16] = '{'{0, 8'h00, 0, 16'h0064}, '{0, 8'h11, 0, 16'h0064},
      '{0, 8'h13, 0, 0}, '{0, 8'h14, 0, 3}, '{0, 8'h15, 0, 8}, '{0, 8'h16, 0, 1},
      '{0, 8'h02, 0, 0}, '{1, 8'h05, 16'h0009, 0}, '{1, 8'h05, 16'h0400, 0},
      '{1, 8'h05, 16'h03f8, 16'h03f8}, '{1, 8'h04, 16'h03e6, 0}, '{1, 8'h04, 16'h07cd, 16'h07cd},
      '{1, 8'h06, 16'h0001, 0}, '{1, 8'h06, 16'h03e8, 0}, '{1, 8'h08, 16'h1234, 0},
      '{1, 8'h07, 16'h0003, 0}};
   // Move rows: channel, mode bits, initial and creep frequency
   run_row_type runs [3] = '{'{0, 2'h3, 16'h2710, 16'h1388}, '{0, 2'h0, 16'h2710, 16'h1388},
      '{1, 2'h1, 16'h09c4, 16'h1388}};
   homing_pulse i_homing_pulse (.CLOCK, .RSTN, .CE, .RUN, .SLOWDOWN, .PRELOAD, .ADDR, .WDATA,
      .WE, .RE, .RDATA, .PULSE_PORT14, .PULSE_PORT15, .PULSE_ON, .PULSE_DONE);
   motor_drive_model i_motor_drive_model (.clock(CLOCK), .rstn(RSTN), .step(pins));
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Half period in clocks for a setting
   function automatic logic [31:0] half(logic [15:0] f, logic x10);
      return CLOCK_HZ / (2 * f * (x10 ? 10 : 1));
   endfunction
   task automatic chk(logic [31:0] got, logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [15:0] d);
      @(posedge CLOCK);
      ADDR <= a;
      WDATA <= d;
      WE <= 1'b1;
      @(posedge CLOCK);
      WE <= 1'b0;
   endtask
   task automatic rd(logic [7:0] a);
      @(posedge CLOCK);
      ADDR <= a;
      RE <= 1'b1;
      @(posedge CLOCK);
      RE <= 1'b0;
      #1 rd_val = RDATA;
   endtask
   // Waits two whole pulses, then compares the last high length
   task automatic meas(int ch, logic [31:0] exp);
      logic [31:0] s;
      int k;
      s = i_motor_drive_model.falls[ch];
      k = 0;
      while (i_motor_drive_model.falls[ch] < s + 2 && k < 30000) begin
         @(posedge CLOCK);
         k++;
      end
      chk(i_motor_drive_model.high[ch], exp);
   endtask
   task automatic conclude();
      $display("checks=%0d mismatches=%0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // ------------------------------------------------------------
   // Clock, watchdog and main sequence
   // ------------------------------------------------------------
   initial begin
      CLOCK = 1'b0;
      forever #20 CLOCK = ~CLOCK;
   end
   initial begin
      repeat (80000) @(posedge CLOCK);
      bad_count++;
      conclude();
   end
   initial begin
      {RSTN, WE, RE, RUN, SLOWDOWN, PRELOAD, ADDR, WDATA} = '0;
      CE = 1'b1;
      repeat (10) @(posedge CLOCK);
      chk(32'({pins, PULSE_ON, PULSE_DONE, RDATA}), 32'h0);
      repeat (10) @(posedge CLOCK);
      RSTN <= 1'b1;
      foreach (regs[i]) begin
         if (regs[i].w) wr(regs[i].a, regs[i].d);
         rd(regs[i].a);
         chk(32'(rd_val), 32'(regs[i].e));
      end
      foreach (runs[i]) begin
         c = runs[i].ch;
         other = i_motor_drive_model.falls[1 - c];
         base = c[0] ? CH_STRIDE : 8'h00;
         wr(base + {4'h0, OFF_INIT_FREQ}, runs[i].fi);
         wr(base + {4'h0, OFF_CREEP_FREQ}, runs[i].fc);
         wr(base + {4'h0, OFF_MODE}, {14'h0, runs[i].m});
         @(posedge CLOCK);
         RUN[c] <= 1'b1;
         meas(c, half(runs[i].fi, runs[i].m[MODE_INIT_BIT]));
         SLOWDOWN[c] <= 1'b1;
         meas(c, half(runs[i].fc, runs[i].m[MODE_CREEP_BIT]));
         SLOWDOWN[c] <= 1'b0;
         repeat (4) @(posedge CLOCK);
         #1 chk(32'({pins[c], PULSE_ON[c], PULSE_DONE[c]}), 32'h1);
         n = i_motor_drive_model.falls[c];
         repeat (300) @(posedge CLOCK);
         chk(i_motor_drive_model.falls[c], n);
         chk(i_motor_drive_model.falls[1 - c], other);
         RUN[c] <= 1'b0;
         @(posedge CLOCK);
      end
      // Run request dropped in mid-move on channel a
      RUN[0] <= 1'b1;
      meas(0, half(16'h2710, 1'b0));
      // Clock enable low freezes the pulse train in mid-move
      CE <= 1'b0;
      n = i_motor_drive_model.falls[0];
      repeat (3000) @(posedge CLOCK);
      chk(i_motor_drive_model.falls[0], n);
      CE <= 1'b1;
      RUN[0] <= 1'b0;
      repeat (4) @(posedge CLOCK);
      #1 chk(32'({pins[0], PULSE_ON[0], PULSE_DONE[0]}), 32'h0);
      // Out-of-range frequency blocks a start on channel b
      wr(8'h10, 16'h0000);
      rd(8'h12);
      chk(32'(rd_val), 32'(ERR_RANGE));
      @(posedge CLOCK);
      RUN[1] <= 1'b1;
      repeat (10) @(posedge CLOCK);
      #1 chk(32'({pins[1], PULSE_ON[1]}), 32'h0);
      RUN[1] <= 1'b0;
      PRELOAD[1] <= 1'b1;
      @(posedge CLOCK);
      PRELOAD[1] <= 1'b0;
      rd(8'h10);
      chk(32'(rd_val), 32'(DEF_INIT_FREQ));
      rd(8'h12);
      chk(32'(rd_val), 32'(ERR_NONE));
      conclude();
   end
endmodule
`default_nettype wire

//--- tb/motor_drive_model.sv
// Motor drive stand-in: counts step pulses and their high length.
// Assumes step lines are registered on the bench clock.
`timescale 1ns/1ns
`default_nettype none
module motor_drive_model (
   input wire logic clock,
   input wire logic rstn,
   input wire logic [1:0] step
);
   logic [31:0] falls [2]; // Completed pulses per channel
   logic [31:0] high [2];  // Clocks of the last high level
   logic [31:0] run [2];   // Clocks high so far
   // Pulse edge bookkeeping per channel
   always_ff @(posedge clock or negedge rstn) begin
      for (int i = 0; i < 2; i++) begin
         if (!rstn) begin
            falls[i] <= 32'h0;
            high[i] <= 32'h0;
            run[i] <= 32'h0;
         end else if (step[i]) begin
            run[i] <= run[i] + 32'h1;
         end else if (run[i] != 32'h0) begin
            high[i] <= run[i];
            falls[i] <= falls[i] + 32'h1;
            run[i] <= 32'h0;
         end
      end
   end
endmodule
`default_nettype wire
